/* wire_master_pkg.sv */
`default_nettype none
package wire_master_pkg;
	localparam logic [4:0]  OFS_CONFIG    = 5'h00;
	localparam logic [4:0]  OFS_DIVISOR   = 5'h04;
	localparam logic [4:0]  OFS_CTRL      = 5'h08;
	localparam logic [4:0]  OFS_BUFFER    = 5'h0C;
	localparam logic [4:0]  OFS_FLAGS     = 5'h10;
	localparam logic [4:0]  OFS_MASK      = 5'h14;
	localparam logic [4:0]  OFS_FLAG_CLR  = 5'h18;
	localparam int          POS_SINGLE    = 5;
	localparam int          POS_OVERDRIVE = 6;
	localparam int          POS_PULLUP    = 7;
	localparam int          POS_SENT      = 0;
	localparam int          POS_RECEIVED  = 1;
	localparam int          POS_BUSY      = 0;
	localparam logic [7:0]  RST_CONFIG    = 8'h00;
	localparam logic [7:0]  RST_DIVISOR   = 8'h01;
	localparam logic [1:0]  RST_FLAGS     = 2'h0;
	localparam logic [1:0]  RST_MASK      = 2'h0;
	// slot timing in microsecond ticks: low drive, sample point, total slot
	localparam logic [6:0]  STD_LOW       = 7'h06;
	localparam logic [6:0]  STD_SAMPLE    = 7'h0F;
	localparam logic [6:0]  STD_SLOT      = 7'h46;
	localparam logic [6:0]  OD_LOW        = 7'h01;
	localparam logic [6:0]  OD_SAMPLE     = 7'h02;
	localparam logic [6:0]  OD_SLOT       = 7'h0A;

	typedef struct packed {
		logic [31:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SLOT  = 3'b010,
		ST_DONE  = 3'b100
	} state_t;
endpackage
`default_nettype wire

/* wire_master.sv */
// Notes on behaviour
// - single-bit mode moves one bit, else byte
// - writing shift buffer while idle starts a transfer
// - single-bit mode uses only bit 0
// - read is a 1 slot; slave pulls low
// - send-done flag set when slots finish
// - send-done interrupts if masked in; W1C
// - sampled bits land in shift buffer
// - receive-ready set when result complete, interrupts if masked in
// - idle wire reads back transmitted ones
// - single-bit select resets to 0
// - config bit 6 selects overdrive timing
// - config bit 7 enables internal pullup
// - all fields reset on every reset
// - byte slots go LSB first
`default_nettype none
module wire_master #(
	parameter int DIV_W = 8
) (
	input  wire logic                      SYS_CLK,
	input  wire logic                      RSTN,
	input  wire logic                      CLK_EN,
	input  wire wire_master_pkg::apb_req_t APB_REQ,
	output logic                           PREADY,
	output logic [31:0]                    PRDATA,
	output logic                           PSLVERR,
	input  wire logic                      WIRE_IN,
	output logic                           WIRE_OUT,
	output logic                           WIRE_OE,
	output logic                           PULLUP_EN,
	output logic                           IRQ
);
	logic [7:0]       config_reg;
	logic [DIV_W-1:0] divisor;
	logic [7:0]       shift_buffer;
	logic [1:0]       flags;
	logic [1:0]       mask;
	wire_master_pkg::state_t state;
	logic [DIV_W-1:0] div_cnt;
	logic             tick;
	logic [6:0]       slot_cnt;
	logic [2:0]       bit_idx;
	logic [2:0]       last_idx;
	logic             tx_bit;
	logic             set_sent;
	logic             set_recv;
	logic             access;
	logic             wr;
	logic [4:0]       addr;
	logic [6:0]       t_low;
	logic [6:0]       t_sample;
	logic [6:0]       t_slot;
	logic             start;
	logic [1:0]       clr;

	// access completes in the access phase; pready is raised one cycle later
	assign access = APB_REQ.psel && APB_REQ.penable && !PREADY;
	assign wr     = access && APB_REQ.pwrite;
	assign addr   = APB_REQ.paddr[4:0];
	assign start  = wr && addr == wire_master_pkg::OFS_BUFFER
		&& state == wire_master_pkg::ST_IDLE;
	assign clr    = (wr && addr == wire_master_pkg::OFS_FLAGS) ? APB_REQ.pwdata[1:0] : 2'h0;

	always_comb begin
		if (config_reg[wire_master_pkg::POS_OVERDRIVE]) begin
			t_low    = wire_master_pkg::OD_LOW;
			t_sample = wire_master_pkg::OD_SAMPLE;
			t_slot   = wire_master_pkg::OD_SLOT;
		end else begin
			t_low    = wire_master_pkg::STD_LOW;
			t_sample = wire_master_pkg::STD_SAMPLE;
			t_slot   = wire_master_pkg::STD_SLOT;
		end
	end

	// registers, reset by the single reset that merges all reset sources
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			config_reg <= wire_master_pkg::RST_CONFIG;
			divisor    <= DIV_W'(wire_master_pkg::RST_DIVISOR);
			mask       <= wire_master_pkg::RST_MASK;
		end else if (CLK_EN && wr) begin
			case (addr)
				wire_master_pkg::OFS_CONFIG: begin
					config_reg <= APB_REQ.pwdata[7:0];
				end
				wire_master_pkg::OFS_DIVISOR: begin
					divisor <= APB_REQ.pwdata[DIV_W-1:0];
				end
				wire_master_pkg::OFS_MASK: begin
					mask <= APB_REQ.pwdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// microsecond tick from divisor
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end else if (CLK_EN) begin
			if (state == wire_master_pkg::ST_IDLE || div_cnt + DIV_W'(1) >= divisor) begin
				div_cnt <= '0;
				tick    <= state != wire_master_pkg::ST_IDLE;
			end else begin
				div_cnt <= div_cnt + DIV_W'(1);
				tick    <= 1'b0;
			end
		end
	end

	logic             in_slot;
	logic             step;
	logic [6:0]       slot_next;
	logic             at_low;
	logic             at_sample;
	logic             at_end;
	logic             last_bit;
	logic             load_single;
	logic [7:0]       load_bits;
	logic [7:0]       next_buffer;
	logic [1:0]       flag_set;
	logic [1:0]       next_flags;
	logic [31:0]      next_prdata;

	// slot events shared by the per-concern processes
	assign tx_bit      = shift_buffer[bit_idx];
	assign in_slot     = state == wire_master_pkg::ST_SLOT;
	assign step        = in_slot && tick;
	assign slot_next   = slot_cnt + 7'h01;
	assign at_low      = step && slot_next == t_low;
	assign at_sample   = step && slot_next == t_sample;
	assign at_end      = step && slot_next == t_slot;
	assign last_bit    = bit_idx == last_idx;
	assign load_single = config_reg[wire_master_pkg::POS_SINGLE];

	// each buffer bit loads with the write, then takes the wire at its own sample point
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_buf
			assign load_bits[gi]   = (gi == 0 || !load_single) ? APB_REQ.pwdata[gi] : 1'b0;
			assign next_buffer[gi] = start ? load_bits[gi]
				: (at_sample && bit_idx == 3'(gi)) ? WIRE_IN : shift_buffer[gi];
		end
	endgenerate

	// shift buffer
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			shift_buffer <= 8'h00;
		end else if (CLK_EN) begin
			shift_buffer <= next_buffer;
		end
	end

	// transfer state
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state <= wire_master_pkg::ST_IDLE;
		end else if (CLK_EN) begin
			case (state)
				wire_master_pkg::ST_IDLE: begin
					if (start) begin
						state <= wire_master_pkg::ST_SLOT;
					end
				end
				wire_master_pkg::ST_SLOT: begin
					if (at_end && last_bit) begin
						state <= wire_master_pkg::ST_DONE;
					end
				end
				wire_master_pkg::ST_DONE: begin
					state <= wire_master_pkg::ST_IDLE;
				end
				default: begin
					state <= wire_master_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// tick count within a slot
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			slot_cnt <= 7'h00;
		end else if (CLK_EN) begin
			if (start || at_end) begin
				slot_cnt <= 7'h00;
			end else if (step) begin
				slot_cnt <= slot_next;
			end
		end
	end

	// bit position, least significant first
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			bit_idx <= 3'h0;
		end else if (CLK_EN) begin
			if (start) begin
				bit_idx <= 3'h0;
			end else if (at_end && !last_bit) begin
				bit_idx <= bit_idx + 3'h1;
			end
		end
	end

	// last bit of the transfer
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			last_idx <= 3'h0;
		end else if (CLK_EN) begin
			if (start) begin
				if (load_single) begin
					last_idx <= 3'h0;
				end else begin
					last_idx <= 3'h7;
				end
			end
		end
	end

	// wire drive: a 1 slot releases early, a 0 slot holds low to the sample point
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			WIRE_OE <= 1'b0;
		end else if (CLK_EN) begin
			if (start) begin
				WIRE_OE <= 1'b1;
			end else if (at_end && !last_bit) begin
				WIRE_OE <= 1'b1;
			end else if (at_sample) begin
				WIRE_OE <= 1'b0;
			end else if (at_low && tx_bit) begin
				WIRE_OE <= 1'b0;
			end
		end
	end

	// send-done event
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			set_sent <= 1'b0;
		end else if (CLK_EN) begin
			set_sent <= state == wire_master_pkg::ST_DONE;
		end
	end

	// receive-ready event
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			set_recv <= 1'b0;
		end else if (CLK_EN) begin
			set_recv <= state == wire_master_pkg::ST_DONE;
		end
	end

	// sticky flags, set wins over clear
	assign flag_set[wire_master_pkg::POS_SENT]     = set_sent;
	assign flag_set[wire_master_pkg::POS_RECEIVED] = set_recv;
	genvar gf;
	generate
		for (gf = 0; gf < 2; gf++) begin : g_flag
			assign next_flags[gf] = flag_set[gf] || (flags[gf] && !clr[gf]);
		end
	endgenerate

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			flags <= wire_master_pkg::RST_FLAGS;
		end else if (CLK_EN) begin
			flags <= next_flags;
		end
	end

	// interrupt level
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			IRQ <= 1'b0;
		end else if (CLK_EN) begin
			IRQ <= |(flags & mask);
		end
	end

	// pullup control
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PULLUP_EN <= 1'b0;
		end else if (CLK_EN) begin
			PULLUP_EN <= config_reg[wire_master_pkg::POS_PULLUP];
		end
	end

	// open drain: the wire is only ever pulled low
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			WIRE_OUT <= 1'b0;
		end else if (CLK_EN) begin
			WIRE_OUT <= 1'b0;
		end
	end

	// read data select
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (access && !APB_REQ.pwrite) begin
			case (addr)
				wire_master_pkg::OFS_CONFIG: begin
					next_prdata = {24'h000000, config_reg};
				end
				wire_master_pkg::OFS_DIVISOR: begin
					next_prdata = 32'(divisor);
				end
				wire_master_pkg::OFS_CTRL: begin
					next_prdata = {31'h0, state != wire_master_pkg::ST_IDLE};
				end
				wire_master_pkg::OFS_BUFFER: begin
					next_prdata = {24'h000000, shift_buffer};
				end
				wire_master_pkg::OFS_FLAGS: begin
					next_prdata = {30'h0, flags};
				end
				wire_master_pkg::OFS_MASK: begin
					next_prdata = {30'h0, mask};
				end
				default: begin
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// apb ready, one cycle after the access phase is seen
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PREADY <= 1'b0;
		end else if (CLK_EN) begin
			PREADY <= access;
		end
	end

	// apb error, never raised
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PSLVERR <= 1'b0;
		end else if (CLK_EN) begin
			PSLVERR <= 1'b0;
		end
	end

	// apb read data, valid with ready
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PRDATA <= 32'h0000_0000;
		end else if (CLK_EN) begin
			PRDATA <= next_prdata;
		end
	end
endmodule
`default_nettype wire

/* wire_master_assertions.sv */
`default_nettype none
module wire_master_assertions #(
	parameter int DIV_W = 8
) (
	input wire logic			SYS_CLK,
	input wire logic			RSTN,
	input wire logic			CLK_EN,
	input wire wire_master_pkg::apb_req_t	APB_REQ,
	input wire logic			PREADY,
	input wire logic [31:0]			PRDATA,
	input wire logic			PSLVERR,
	input wire logic			WIRE_IN,
	input wire logic			WIRE_OUT,
	input wire logic			WIRE_OE,
	input wire logic			PULLUP_EN,
	input wire logic			IRQ
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	wire		wr = PREADY & APB_REQ.psel & APB_REQ.pwrite;
	wire		wsel = APB_REQ.psel & APB_REQ.pwrite;
	wire [31:0]	ad = APB_REQ.paddr;
	ready_answer_a: assert property (CLK_EN && APB_REQ.psel && APB_REQ.penable && !PREADY
		|=> PREADY) else $error("access not answered");
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held too long");
	rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0) else $error("stray read data");
	no_error_a: assert property (!PSLVERR) else $error("error response raised");
	open_drain_a: assert property (!WIRE_OUT) else $error("wire driven high");
	pullup_cfg_a: assert property (wr && ad == 32'h0 |-> ##2
		PULLUP_EN == $past(APB_REQ.pwdata[7], 2)) else $error("pullup not following config");
	slot_start_a: assert property (wr && ad == 32'hC |-> ##[1:3] WIRE_OE)
		else $error("buffer write started no slot");
	irq_clear_a: assert property ($fell(IRQ) |-> $past(wsel) || $past(wsel, 2))
		else $error("interrupt dropped without a write");
	cover property ($rose(IRQ));
	cover property (wr && ad == 32'hC);
	cover property ($rose(PULLUP_EN));
endmodule
bind wire_master wire_master_assertions #(.DIV_W(DIV_W)) chk (.*);
`default_nettype wire

/* wire_slave.sv */
`default_nettype none
module wire_slave (
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	oe,
	input wire logic [7:0]	reply,
	input wire logic [7:0]	hold,
	output logic		line,
	output logic [3:0]	slots
);
	timeunit 1ns;
	timeprecision 1ps;
	logic		pull;
	logic		oe_q;
	logic [7:0]	cnt;
	// released line floats high through the pullup
	assign line = !(oe | pull);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{pull, oe_q, cnt, slots} <= '0;
		end else begin
			oe_q <= oe;
			if (oe && !oe_q) begin
				pull <= !reply[slots[2:0]];
				cnt <= hold;
				slots <= slots + 4'h1;
			end else if (cnt != 8'h0) begin
				cnt <= cnt - 8'h1;
			end else begin
				pull <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* single_wire_master_read_tb.sv */
`default_nettype none
module single_wire_master_read_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic				SYS_CLK, RSTN, s_rstn;
	wire_master_pkg::apb_req_t	req;
	logic				PREADY, PSLVERR, WIRE_IN, WIRE_OUT, WIRE_OE, PULLUP_EN, IRQ;
	logic [31:0]			PRDATA, rd;
	logic [7:0]			reply, hold;
	logic [3:0]			slots;
	int				n_mismatch, checks, cyc = 0;
	wire_master dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CLK_EN(1'b1), .APB_REQ(req),
		.PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .WIRE_IN(WIRE_IN),
		.WIRE_OUT(WIRE_OUT), .WIRE_OE(WIRE_OE), .PULLUP_EN(PULLUP_EN), .IRQ(IRQ));
	wire_slave slave (.clk(SYS_CLK), .rst_n(s_rstn), .oe(WIRE_OE), .reply(reply),
		.hold(hold), .line(WIRE_IN), .slots(slots));
	initial begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end
	task automatic conclude();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		req <= '{a, 1'b1, 1'b0, wr, d};
		@(posedge SYS_CLK);
		req.penable <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	// one transfer with the slave answering rep, pulling for h+1 cycles per zero
	task automatic xfer(input logic [7:0] data, input logic [7:0] rep, input logic [7:0] h);
		reply <= rep;
		hold <= h;
		s_rstn <= 1'b0;
		@(posedge SYS_CLK);
		s_rstn <= 1'b1;
		apb(1'b1, 32'hC, {24'h0, data});
		do apb(1'b0, 32'h8, 32'h0); while (rd[0] !== 1'b0);
	endtask
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		{RSTN, s_rstn, req, reply, hold, n_mismatch, checks} = '0;
		repeat (3) @(posedge SYS_CLK);
		RSTN <= 1'b1;
		@(posedge SYS_CLK);
		rchk("config", 32'h0, 32'h0);
		rchk("divisor", 32'h4, 32'h1);
		rchk("flags", 32'h10, 32'h0);
		rchk("mask", 32'h14, 32'h0);
		chk("pullup", 32'h0, {31'h0, PULLUP_EN});
		apb(1'b1, 32'h0, 32'h80);
		rchk("config", 32'h0, 32'h80);
		chk("pullup", 32'h1, {31'h0, PULLUP_EN});
		apb(1'b1, 32'h1C, 32'hFFFFFFFF);
		rchk("unmapped", 32'h1C, 32'h0);
		apb(1'b1, 32'h4, 32'h2);
		apb(1'b1, 32'h14, 32'h3);
		apb(1'b1, 32'h0, 32'h0);
		xfer(8'hFF, 8'hFF, 8'h28);
		rchk("idle byte", 32'hC, 32'hFF);
		chk("slots", 32'h8, {28'h0, slots});
		rchk("flags", 32'h10, 32'h3);
		chk("irq", 32'h1, {31'h0, IRQ});
		apb(1'b1, 32'h10, 32'h1);
		rchk("flags", 32'h10, 32'h2);
		chk("irq", 32'h1, {31'h0, IRQ});
		apb(1'b1, 32'h10, 32'h2);
		rchk("flags", 32'h10, 32'h0);
		chk("irq", 32'h0, {31'h0, IRQ});
		xfer(8'hFF, 8'hA5, 8'h28);
		rchk("byte", 32'hC, 32'hA5);
		apb(1'b1, 32'h0, 32'h40);
		xfer(8'hFF, 8'h3C, 8'h08);
		rchk("fast byte", 32'hC, 32'h3C);
		apb(1'b1, 32'h14, 32'h0);
		apb(1'b1, 32'h10, 32'h3);
		apb(1'b1, 32'h0, 32'h20);
		xfer(8'hFE, 8'hFF, 8'h28);
		rchk("bit zero", 32'hC, 32'h0);
		xfer(8'hFF, 8'hFF, 8'h28);
		rchk("bit one", 32'hC, 32'h1);
		chk("slots", 32'h1, {28'h0, slots});
		chk("irq", 32'h0, {31'h0, IRQ});
		apb(1'b1, 32'h14, 32'h2);
		rchk("flags", 32'h10, 32'h3);
		chk("irq", 32'h1, {31'h0, IRQ});
		RSTN <= 1'b0;
		@(posedge SYS_CLK);
		RSTN <= 1'b1;
		@(posedge SYS_CLK);
		chk("irq", 32'h0, {31'h0, IRQ});
		rchk("config", 32'h0, 32'h0);
		rchk("flags", 32'h10, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
